/* adms_cfg.svh */
// constants for the converter mode sequencer
`ifndef ADMS_CFG_SVH
`define ADMS_CFG_SVH
`define ADMS_OFF_CTRL 4'h0
`define ADMS_OFF_CTRL2 4'h1
`define ADMS_OFF_STATUS 4'h2
`define ADMS_OFF_MASK 4'h3
`define ADMS_OFF_RES0 4'h8
`define ADMS_CTRL_MODE_LO 0
`define ADMS_CTRL_CHAN_LO 3
`define ADMS_CTRL_GRP_LO 6
`define ADMS_CTRL_TRIG 8
`define ADMS_CTRL_START 9
`define ADMS_CTRL_RES10 10
`define ADMS_CTRL2_SH 0
`define ADMS_CYC_8BIT 28
`define ADMS_CYC_10BIT 33
`define ADMS_CLK_MHZ 100
`endif

/* adms_pkg.sv */
// types for the converter mode sequencer
`default_nettype none
package adms_pkg;
  typedef enum logic [2:0] {
    adms_one_shot = 3'h0,
    adms_repeat = 3'h1,
    adms_single_sweep = 3'h2,
    adms_repeat_sweep0 = 3'h3,
    adms_repeat_sweep1 = 3'h4
  } adms_mode_e;
  typedef enum logic [1:0] {
    adms_idle = 2'h0,
    adms_wait_trig = 2'h1,
    adms_convert = 2'h2
  } adms_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } adms_bus_s;
  typedef struct packed {
    logic start;
    logic [2:0] chan;
    logic res10;
  } adms_core_req_s;
endpackage
`default_nettype wire

/* adms_sequencer.sv */
// mode sequencer for the eight-channel successive-approximation converter
// How it works
// R1 - one-shot converts selected channel once
// R2 - writing start flag one begins run
// R3 - single runs clear start unless triggered externally
// R4 - writing start flag zero stops conversion
// R5 - interrupt only at end of single runs
// R6 - one-shot and repeat modes pick any of eight channels
// R7 - repeat mode converts channel until stopped
// R8 - single sweep converts group once each
// R9 - sweep group is lowest 2,4,6,8 channels
// R10 - repeat sweep 0 loops group until stopped
// R11 - each channel has own result register
// R12 - results readable anytime, latest value
// R13 - sweep 1 interleaves emphasized group
// R14 - emphasized group is lowest 1-4 channels
// R15 - group ascending; result updates on completion
// R16 - falling external trigger starts, may retrigger
// R17 - software selects 8 or 10 bit
// R18 - sample-and-hold bit must precede start; start does not check sh_en, which is only stored and read back
// R19 - conversion lasts 28 or 33 cycles
`include "adms_cfg.svh"
`default_nettype none
module adms_sequencer #(
  parameter int CHANNELS = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire adms_pkg::adms_bus_s bus,
  output logic [15:0] rdata,
  input wire logic external_conversion_trigger,
  output adms_pkg::adms_core_req_s core_req,
  output logic [2:0] core_chan,
  input wire logic core_done,
  input wire logic [9:0] core_result,
  output logic irq
);
  import adms_pkg::*;

  localparam logic [5:0] CYC8 = 6'(`ADMS_CYC_8BIT);
  localparam logic [5:0] CYC10 = 6'(`ADMS_CYC_10BIT);

  logic [10:0] ctrl;
  logic sh_en;
  logic status;
  logic mask;
  logic [9:0] result [CHANNELS];
  adms_state_e state;
  logic [2:0] chan;
  logic [2:0] outer;
  logic in_emph;
  logic [5:0] cnt;
  logic trig_q;

  wire [2:0] mode_raw = ctrl[`ADMS_CTRL_MODE_LO +: 3];
  wire adms_mode_e mode = adms_mode_e'(mode_raw);
  wire [2:0] sel_chan = ctrl[`ADMS_CTRL_CHAN_LO +: 3];
  wire [1:0] grp = ctrl[`ADMS_CTRL_GRP_LO +: 2];
  wire ext_trig = ctrl[`ADMS_CTRL_TRIG];
  wire start_flag = ctrl[`ADMS_CTRL_START];
  wire res10 = ctrl[`ADMS_CTRL_RES10];

  wire wr_ctrl = bus.wr && bus.addr == `ADMS_OFF_CTRL;
  wire wr_ctrl2 = bus.wr && bus.addr == `ADMS_OFF_CTRL2;
  wire wr_stat = bus.wr && bus.addr == `ADMS_OFF_STATUS;
  wire wr_mask = bus.wr && bus.addr == `ADMS_OFF_MASK;
  wire new_start = bus.wdata[`ADMS_CTRL_START];
  wire start_rise = wr_ctrl && new_start; // R2
  wire stop_req = wr_ctrl && !new_start; // R4
  wire trig_fall = trig_q && !external_conversion_trigger; // R16

  // last channel of the sweep group: 1,3,5,7
  wire [2:0] sweep_last = {grp, 1'b1}; // R9
  // last emphasized channel: 0..3
  wire [2:0] emph_last = {1'b0, grp}; // R14
  wire single_mode = mode == adms_one_shot || mode == adms_single_sweep;
  wire chan_mode = mode == adms_one_shot || mode == adms_repeat;
  wire [5:0] conv_len = res10 ? CYC10 : CYC8; // R17 R19
  wire conv_end = state == adms_convert && core_done;

  // first channel of a run: the selected one, or channel zero for sweeps
  // decoded from the written word too, since ctrl still holds the old mode
  function automatic logic [2:0] run_first(input logic [2:0] m,
    input logic [2:0] c);
    run_first = (m == adms_one_shot || m == adms_repeat) ? c : 3'h0;
  endfunction

  // first outer channel in sweep 1 sits just above the emphasized group
  function automatic logic [2:0] outer_first(input logic [1:0] g);
    outer_first = {1'b0, g} + 3'h1;
  endfunction

  wire [2:0] new_first = run_first(bus.wdata[2:0], bus.wdata[5:3]); // R6
  wire [2:0] new_outer = outer_first(bus.wdata[7:6]); // R14

  // next channel in sweep 1: emph group ascending, then one outer channel
  function automatic logic [3:0] sweep1_next(input logic [2:0] c,
    input logic emph, input logic [2:0] o, input logic [2:0] el);
    if (emph && c != el)
      sweep1_next = {1'b1, c + 3'h1};
    else if (emph)
      sweep1_next = {1'b0, o};
    else
      sweep1_next = {1'b1, 3'h0};
    if (emph && c == el && el == 3'h7)
      sweep1_next = {1'b1, 3'h0};
  endfunction

  wire [3:0] s1 = sweep1_next(chan, in_emph, outer, emph_last); // R13 R15
  wire [2:0] outer_adv = (outer == 3'h7) ? emph_last + 3'h1 : outer + 3'h1;
  wire run_last = (mode == adms_one_shot) ||
    (mode == adms_single_sweep && chan == sweep_last); // R1 R8
  wire [2:0] first_chan = run_first(mode_raw, sel_chan); // R6

  wire [2:0] next_chan =
    chan_mode ? sel_chan : // R7
    (mode == adms_repeat_sweep1) ? s1[2:0] :
    (chan == sweep_last) ? 3'h0 : chan + 3'h1; // R10

  wire [15:0] ctrl_rd = {5'h0, ctrl};
  wire [15:0] res_rd = {6'h0, result[bus.addr[2:0]]}; // R11 R12
  wire [15:0] next_rdata =
    (bus.addr == `ADMS_OFF_CTRL) ? ctrl_rd :
    (bus.addr == `ADMS_OFF_CTRL2) ? {15'h0, sh_en} :
    (bus.addr == `ADMS_OFF_STATUS) ? {15'h0, status} :
    (bus.addr == `ADMS_OFF_MASK) ? {15'h0, mask} :
    bus.addr[3] ? res_rd : 16'h0;

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= 11'h0;
      sh_en <= 1'b0;
      mask <= 1'b0;
      rdata <= 16'h0;
      trig_q <= 1'b1;
    end else begin
      trig_q <= external_conversion_trigger;
      rdata <= bus.rd ? next_rdata : 16'h0;
      if (wr_ctrl2)
        sh_en <= bus.wdata[`ADMS_CTRL2_SH]; // R18
      if (wr_mask)
        mask <= bus.wdata[0];
      if (wr_ctrl)
        ctrl <= bus.wdata[10:0];
      else if (conv_end && run_last && !ext_trig)
        ctrl[`ADMS_CTRL_START] <= 1'b0; // R3
    end
  end

  // set wins over a same-cycle write-one clear
  wire irq_event = conv_end && run_last && single_mode && !stop_req; // R5
  always_ff @(posedge clock) begin
    if (rst)
      status <= 1'b0;
    else if (irq_event)
      status <= 1'b1;
    else if (wr_stat && bus.wdata[0])
      status <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (status || irq_event) && mask;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= adms_idle;
      chan <= 3'h0;
      outer <= 3'h0;
      in_emph <= 1'b0;
      cnt <= 6'h0;
    end else begin
      case (state)
        adms_idle: begin
          if (start_rise && !bus.wdata[`ADMS_CTRL_TRIG]) begin
            state <= adms_convert; // R2
            chan <= new_first; // R6
            in_emph <= 1'b1;
            outer <= new_outer; // R14
          end else if (start_rise)
            state <= adms_wait_trig;
        end
        adms_wait_trig: begin
          if (stop_req)
            state <= adms_idle; // R4
          else if (trig_fall && start_flag) begin
            state <= adms_convert; // R16
            chan <= first_chan;
            in_emph <= 1'b1;
            outer <= emph_last + 3'h1;
          end
        end
        adms_convert: begin
          cnt <= cnt + 6'h1;
          if (stop_req)
            state <= adms_idle; // R4
          else if (ext_trig && trig_fall) begin
            chan <= first_chan; // R16
            in_emph <= 1'b1;
            outer <= emph_last + 3'h1;
            // restart the core too, else its result lands on the new channel
            cnt <= 6'h0;
          end else if (core_done) begin
            cnt <= 6'h0;
            if (run_last)
              state <= ext_trig ? adms_wait_trig : adms_idle; // R1 R8
            else begin
              chan <= next_chan;
              if (mode == adms_repeat_sweep1) begin
                in_emph <= s1[3];
                if (!in_emph)
                  outer <= outer;
                else if (chan == emph_last)
                  outer <= outer_adv;
              end
            end
          end
        end
        default: state <= adms_idle;
      endcase
    end
  end

  // result written only when its own conversion completes
  always_ff @(posedge clock) begin
    if (conv_end && !stop_req)
      result[chan] <= res10 ? core_result : {core_result[9:2], 2'h0}; // R15
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      core_req <= '0;
      core_chan <= 3'h0;
    end else begin
      core_req.start <= state == adms_convert && cnt == 6'h0 && !core_done;
      core_req.chan <= chan;
      core_req.res10 <= res10;
      core_chan <= chan;
    end
  end

  conv_len_a: assert property (@(posedge clock) disable iff (rst) // R17
    core_req.start |-> core_req.res10 == $past(res10))
    else $error("resolution not passed to core");

  oneshot_clear_a: assert property (@(posedge clock) disable iff (rst)
    conv_end && mode == adms_one_shot && !ext_trig && !wr_ctrl
    |=> !start_flag) // R3
    else $error("start flag not cleared after one-shot");

  repeat_noirq_a: assert property (@(posedge clock) disable iff (rst)
    !single_mode && !status |=> !status) // R5
    else $error("interrupt in repeat mode");

  stop_idle_a: assert property (@(posedge clock) disable iff (rst)
    stop_req |=> state == adms_idle) // R4
    else $error("stop did not idle");

  start_run_a: assert property (@(posedge clock) disable iff (rst)
    start_rise && state == adms_idle && !bus.wdata[`ADMS_CTRL_TRIG]
    |=> state == adms_convert) // R2
    else $error("start did not begin");

  start_chan_a: assert property (@(posedge clock) disable iff (rst) // R6
    start_rise && state == adms_idle && !bus.wdata[`ADMS_CTRL_TRIG]
    |=> chan == $past(new_first))
    else $error("run began on wrong channel");

  sweep_wrap_a: assert property (@(posedge clock) disable iff (rst)
    conv_end && mode == adms_repeat_sweep0 && chan == sweep_last
    && !stop_req && !wr_ctrl && !trig_fall |=> chan == 3'h0) // R10
    else $error("sweep did not wrap");

  repeat_chan_a: assert property (@(posedge clock) disable iff (rst)
    state == adms_convert && mode == adms_repeat && !wr_ctrl
    |=> chan == sel_chan) // R7
    else $error("repeat channel changed");

  irq_mask_a: assert property (@(posedge clock) disable iff (rst)
    status && mask |=> irq) // R5
    else $error("masked interrupt wrong");

  set_wins_a: assert property (@(posedge clock) disable iff (rst) // R5
    irq_event |=> status)
    else $error("status not set at end of run");

  sweep_bound_a: assert property (@(posedge clock) disable iff (rst)
    state == adms_convert && mode == adms_single_sweep
    |-> chan <= sweep_last) // R9
    else $error("sweep channel out of group");

  emph_return_a: assert property (@(posedge clock) disable iff (rst)
    conv_end && mode == adms_repeat_sweep1 && !in_emph && !stop_req
    && !wr_ctrl && !trig_fall |=> chan == 3'h0) // R13
    else $error("no return to emphasized group");

  outer_range_a: assert property (@(posedge clock) disable iff (rst) // R14
    state == adms_convert && mode == adms_repeat_sweep1 && !in_emph
    |-> chan > emph_last)
    else $error("outer channel inside emphasized group");

  // limitation: results have no reset, only a finished conversion fills them
  result_store_a: assert property (@(posedge clock) disable iff (rst) // R15
    conv_end && !stop_req && res10
    |=> result[$past(chan)] == $past(core_result))
    else $error("result not stored for its channel");

  res8_low_a: assert property (@(posedge clock) disable iff (rst) // R17
    conv_end && !stop_req && !res10
    |=> result[$past(chan)][1:0] == 2'h0)
    else $error("low bits set at 8-bit resolution");

  trig_wait_a: assert property (@(posedge clock) disable iff (rst) // R16
    state == adms_wait_trig && !trig_fall && !stop_req
    |=> state == adms_wait_trig)
    else $error("run began without trigger edge");

  rdata_idle_a: assert property (@(posedge clock) disable iff (rst) // R11
    !bus.rd |=> rdata == 16'h0)
    else $error("read data without read strobe");

  c_oneshot: cover property (@(posedge clock) irq_event);
  c_repeat: cover property (@(posedge clock)
    conv_end && mode == adms_repeat);
  c_stop: cover property (@(posedge clock)
    stop_req && state == adms_convert);
  c_sweep1: cover property (@(posedge clock)
    conv_end && mode == adms_repeat_sweep1 && chan == 3'h7);
  c_trig: cover property (@(posedge clock)
    state == adms_wait_trig ##1 state == adms_convert);
endmodule
`default_nettype wire

/* adms_core_model.sv */
// behavioural analog core answering each channel request
`default_nettype none
module adms_core_model (
  input wire logic clock,
  input wire adms_pkg::adms_core_req_s core_req,
  output logic core_done,
  output logic [9:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import adms_pkg::*;
  int cnt = 0;
  logic [2:0] ch = 3'h0;
  initial core_done = 1'b0;
  initial core_result = 10'h0;
  always @(posedge clock) begin
    core_done <= 1'b0;
    // result only valid with done, garbage otherwise
    core_result <= ~core_result;
    if (core_req.start) begin
      cnt <= core_req.res10 ? 33 : 28;
      ch <= core_req.chan;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (!core_req.start && cnt == 1) begin
      core_done <= 1'b1;
      core_result <= {ch, 7'h35};
    end
  end
endmodule
`default_nettype wire

/* tb_adms_sequencer.sv */
// self-checking bench for the converter mode sequencer
`default_nettype none
module tb_adms_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import adms_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  adms_bus_s bus = '0;
  logic trig = 1'b1;
  logic [15:0] rdata;
  adms_core_req_s core_req;
  logic [2:0] core_chan;
  logic core_done;
  logic [9:0] core_result;
  logic irq;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  logic [2:0] seen[$];
  always #5 clock = ~clock;
  adms_sequencer adms_sequencer_i (.clock(clock), .rst(rst), .bus(bus),
    .rdata(rdata), .external_conversion_trigger(trig),
    .core_req(core_req), .core_chan(core_chan), .core_done(core_done),
    .core_result(core_result), .irq(irq));
  adms_core_model adms_core_model_i (.clock(clock), .core_req(core_req),
    .core_done(core_done), .core_result(core_result));
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (core_req.start === 1'b1) seen.push_back(core_req.chan);
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] ctl(input logic [2:0] m,
    input logic [2:0] c, input logic [1:0] g, input logic t, input logic s);
    return {5'h0, 1'b1, s, t, g, c, m};
  endfunction
  // idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    check(rdata, exp);
    @(posedge clock);
  endtask
  // runs ctrl until the channel list is seen, then compares it
  task automatic go(input logic [15:0] c, input logic [2:0] exp[$]);
    seen.delete();
    wr(4'h0, c);
    while (seen.size() < exp.size()) @(posedge clock);
    foreach (exp[i]) check(16'(seen[i]), 16'(exp[i]));
  endtask
  task automatic end_irq(input int n);
    while (irq !== 1'b1) @(posedge clock);
    repeat (40) @(posedge clock);
    check(16'(seen.size()), 16'(n));
    rd(4'h2, 16'h0001);
    wr(4'h2, 16'h0001);
    @(negedge clock);
    check(16'(irq), 16'h0);
    @(posedge clock);
    rd(4'h2, 16'h0);
  endtask
  task automatic stop_quiet();
    wr(4'h0, 16'h0);
    repeat (40) @(posedge clock);
    seen.delete();
    repeat (80) @(posedge clock);
    check(16'(seen.size()), 16'h0);
    check(16'(irq), 16'h0);
  endtask
  task automatic t_one_shot();
    go(ctl(3'h0, 3'h5, 2'h0, 1'b0, 1'b1), '{3'h5});
    end_irq(1);
    rd(4'h0, ctl(3'h0, 3'h5, 2'h0, 1'b0, 1'b0));
    rd(4'hD, {6'h0, 3'h5, 7'h35});
    $display("one-shot test ended");
  endtask
  task automatic t_sweep();
    go(ctl(3'h2, 3'h0, 2'h1, 1'b0, 1'b1), '{0, 1, 2, 3});
    end_irq(4);
    for (int i = 0; i < 4; i++) rd(4'(8 + i), {6'h0, 3'(i), 7'h35});
    $display("single sweep test ended");
  endtask
  task automatic t_sweep1();
    go(ctl(3'h4, 3'h0, 2'h1, 1'b0, 1'b1),
      '{0, 1, 2, 0, 1, 3, 0, 1, 4});
    rd(4'hA, {6'h0, 3'h2, 7'h35});
    stop_quiet();
    $display("repeat sweep 1 test ended");
  endtask
  task automatic t_sweep0_repeat();
    go(ctl(3'h3, 3'h0, 2'h0, 1'b0, 1'b1), '{0, 1, 0, 1});
    stop_quiet();
    go(ctl(3'h1, 3'h6, 2'h0, 1'b0, 1'b1), '{6, 6, 6});
    stop_quiet();
    $display("repeat modes test ended");
  endtask
  task automatic t_ext();
    seen.delete();
    wr(4'h0, ctl(3'h0, 3'h2, 2'h0, 1'b1, 1'b1));
    repeat (60) @(posedge clock);
    check(16'(seen.size()), 16'h0);
    trig <= 1'b0;
    @(posedge clock);
    trig <= 1'b1;
    end_irq(1);
    check(16'(seen[0]), 16'h2);
    rd(4'h0, ctl(3'h0, 3'h2, 2'h0, 1'b1, 1'b1));
    $display("external trigger test ended");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    wr(4'h1, 16'h0001);
    wr(4'h3, 16'h0001);
    t_one_shot();
    t_sweep();
    t_sweep1();
    t_sweep0_repeat();
    t_ext();
    test_done();
  end
endmodule
`default_nettype wire
